// ---- verilog/hdlc_tx_defs.vh ----
/*
  Constants for the HDLC data link transmitter: register offsets, field
  positions, reset values, line patterns and CRC constants.
  Assumes inclusion by bare name from the design file; definitions only.
*/
`ifndef HDLC_TX_DEFS_VH
`define HDLC_TX_DEFS_VH

// Register byte offsets on the 8-bit register port
`define DL_TX_CONFIG_ADDR 8'h34
`define DL_TX_STATUS_ADDR 8'h35
`define DL_TX_DATA_ADDR 8'h36
`define DL_TX_OPTIONS_ADDR 8'h3F

// Configuration fields
`define CFG_ENABLE_BIT 0
`define CFG_CRC_BIT 1
`define CFG_ABORT_BIT 2
`define CFG_IRQ_GATE_BIT 3
`define CFG_EOP_BIT 4

// Status fields
`define STAT_UNDERRUN_BIT 0
`define STAT_BYTE_REQ_BIT 1

// Options fields
`define OPT_ROUTE_BIT 0

// Reset values
`define CONFIG_RESET 5'h00
`define UNDERRUN_RESET 1'b0
`define BYTE_REQ_RESET 1'b1
`define ROUTE_RESET 1'b0

// Line patterns, sent least significant bit first
`define FLAG_PATTERN 16'h007E
`define ABORT_PATTERN 16'h007F
`define ONES_PATTERN 16'h00FF

// Frame check sequence: x^16 + x^12 + x^5 + 1
`define CRC_POLY 16'h1021
`define CRC_INIT 16'hFFFF

// Bit counts per unit and transparency run length
`define BYTE_LAST 4'h7
`define FCS_LAST 4'hF
`define STUFF_RUN 3'h5

`endif

// ---- verilog/hdlc_datalink_transmitter.v ----
/*
  HDLC transmitter for a T1 facility data link: register port, byte
  holding register, flag/abort/idle generation, zero insertion, CRC-16.
  Assumes the transmit framer pulses i_bit_strobe once per data link bit
  slot (synchronous to i_clock) and samples o_dl_bit after that pulse.
*/
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`include "hdlc_tx_defs.vh"

module hdlc_datalink_transmitter (
    input wire i_clock,
    input wire i_reset,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_write,
    input wire i_read,
    output reg [7:0] o_rdata,
    input wire i_bit_strobe,
    output wire o_dl_bit,
    output wire o_datalink_irq_out,
    output wire o_cpu_irq_n
);

    localparam ST_IDLE = 3'd0;
    localparam ST_FLAG = 3'd1;
    localparam ST_DATA = 3'd2;
    localparam ST_FCS = 3'd3;
    localparam ST_ABORT = 3'd4;
    localparam ST_UDR_ABORT = 3'd5;
    localparam ST_UDR_FLAG = 3'd6;
    localparam ST_ALL_ONES = 3'd7;

    // One serial step of the CRC; data enters least significant bit first
    function [15:0] crc_step;
        input [15:0] crc;
        input din;
        begin
            if (crc[15] ^ din) begin
                crc_step = {crc[14:0], 1'b0} ^ `CRC_POLY;
            end else begin
                crc_step = {crc[14:0], 1'b0};
            end
        end
    endfunction

    reg enable_ff;
    reg crc_enable_ff;
    reg abort_request_ff;
    reg irq_gate_bit_ff;
    reg end_of_packet_mark_ff;
    reg underrun_flag_ff;
    reg route_enable_ff;
    reg [7:0] hold_data_ff;
    reg hold_full_ff;
    reg [2:0] state_ff;
    reg [15:0] shift_ff;
    reg [15:0] crc_ff;
    reg [3:0] bit_count_ff;
    reg [2:0] ones_ff;
    reg line_bit_ff;

    reg [2:0] nxt_state;
    reg nxt_udr_set;
    wire cfg_write;
    wire stat_write;
    wire data_write;
    wire opt_write;
    wire stuff_now;
    wire cur_bit;
    wire unit_last;
    wire advance;
    wire load_byte;
    wire [15:0] crc_upd;
    wire packet_close;
    wire byte_request;

    assign cfg_write = i_write && (i_addr == `DL_TX_CONFIG_ADDR);
    assign stat_write = i_write && (i_addr == `DL_TX_STATUS_ADDR);
    assign data_write = i_write && (i_addr == `DL_TX_DATA_ADDR);
    assign opt_write = i_write && (i_addr == `DL_TX_OPTIONS_ADDR);

    assign byte_request = ~hold_full_ff;

    // Zero insertion also covers a run of five ones that closes a byte
    assign stuff_now = (ones_ff == `STUFF_RUN) && (state_ff != ST_IDLE);

    assign cur_bit = (state_ff == ST_FCS) ? shift_ff[15] : shift_ff[0];

    assign unit_last = (state_ff == ST_IDLE) ||
        (bit_count_ff == ((state_ff == ST_FCS) ? `FCS_LAST : `BYTE_LAST));

    assign advance = i_bit_strobe && enable_ff && !stuff_now;

    assign crc_upd = (state_ff == ST_DATA) ? crc_step(crc_ff, cur_bit) : crc_ff;

    assign load_byte = advance && unit_last && (nxt_state == ST_DATA);

    // A byte still held when the mark is set is the closing byte, so wait for it
    assign packet_close = advance && unit_last && (state_ff == ST_DATA) &&
        end_of_packet_mark_ff && !abort_request_ff && !hold_full_ff;

    // Next unit once the current byte or pattern is fully out
    always @* begin
        nxt_state = ST_FLAG;
        nxt_udr_set = 1'b0;
        if (abort_request_ff) begin
            nxt_state = ST_ABORT;
        end else begin
            case (state_ff)
                ST_DATA: begin
                    if (hold_full_ff) begin
                        nxt_state = ST_DATA;
                    end else if (end_of_packet_mark_ff) begin
                        nxt_state = crc_enable_ff ? ST_FCS : ST_FLAG;
                    end else begin
                        nxt_state = ST_UDR_ABORT;
                        nxt_udr_set = 1'b1;
                    end
                end
                ST_FCS: begin
                    nxt_state = ST_FLAG;
                end
                ST_UDR_ABORT: begin
                    nxt_state = ST_UDR_FLAG;
                end
                ST_UDR_FLAG: begin
                    if (underrun_flag_ff) begin
                        nxt_state = ST_ALL_ONES;
                    end else if (hold_full_ff) begin
                        nxt_state = ST_DATA;
                    end else begin
                        nxt_state = ST_FLAG;
                    end
                end
                ST_ALL_ONES: begin
                    // Leaving idle ones needs an opening flag before any data
                    nxt_state = underrun_flag_ff ? ST_ALL_ONES : ST_FLAG;
                end
                ST_FLAG: begin
                    nxt_state = hold_full_ff ? ST_DATA : ST_FLAG;
                end
                ST_IDLE, ST_ABORT: begin
                    nxt_state = ST_FLAG;
                end
                default: begin
                    nxt_state = ST_FLAG;
                end
            endcase
        end
    end

    // Configuration and option registers
    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            enable_ff <= 1'b0;
            crc_enable_ff <= 1'b0;
            abort_request_ff <= 1'b0;
            irq_gate_bit_ff <= 1'b0;
            end_of_packet_mark_ff <= 1'b0;
            route_enable_ff <= `ROUTE_RESET;
        end else begin
            if (cfg_write) begin
                enable_ff <= i_wdata[`CFG_ENABLE_BIT];
                crc_enable_ff <= i_wdata[`CFG_CRC_BIT];
                abort_request_ff <= i_wdata[`CFG_ABORT_BIT];
                irq_gate_bit_ff <= i_wdata[`CFG_IRQ_GATE_BIT];
            end
            // A software set in the closing cycle wins over the self-clear
            if (cfg_write && i_wdata[`CFG_EOP_BIT]) begin
                end_of_packet_mark_ff <= 1'b1;
            end else if (packet_close) begin
                end_of_packet_mark_ff <= 1'b0;
            end else if (cfg_write) begin
                end_of_packet_mark_ff <= 1'b0;
            end
            if (opt_write) begin
                route_enable_ff <= i_wdata[`OPT_ROUTE_BIT];
            end
        end
    end

    // Holding register and underrun flag
    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            hold_data_ff <= 8'h00;
            hold_full_ff <= 1'b0;
            underrun_flag_ff <= `UNDERRUN_RESET;
        end else begin
            if (data_write) begin
                hold_data_ff <= i_wdata;
            end
            // A write landing with the load keeps the register full
            if (data_write) begin
                hold_full_ff <= 1'b1;
            end else if (load_byte) begin
                hold_full_ff <= 1'b0;
            end
            if (advance && unit_last && nxt_udr_set) begin
                underrun_flag_ff <= 1'b1;
            end else if (stat_write && !i_wdata[`STAT_UNDERRUN_BIT]) begin
                underrun_flag_ff <= 1'b0;
            end
        end
    end

    // Serialiser
    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            state_ff <= ST_IDLE;
            shift_ff <= `ONES_PATTERN;
            crc_ff <= `CRC_INIT;
            bit_count_ff <= 4'h0;
            ones_ff <= 3'h0;
            line_bit_ff <= 1'b1;
        end else if (i_bit_strobe) begin
            if (!enable_ff) begin
                // Inactive link idles marking; restart begins with a flag, or with an abort if the abort bit is set
                state_ff <= ST_IDLE;
                shift_ff <= `ONES_PATTERN;
                bit_count_ff <= 4'h0;
                ones_ff <= 3'h0;
                line_bit_ff <= 1'b1;
            end else if (stuff_now) begin
                line_bit_ff <= 1'b0;
                ones_ff <= 3'h0;
            end else begin
                line_bit_ff <= cur_bit;
                if ((state_ff == ST_DATA) || (state_ff == ST_FCS)) begin
                    ones_ff <= cur_bit ? ones_ff + 3'h1 : 3'h0;
                end else begin
                    ones_ff <= 3'h0;
                end
                crc_ff <= crc_upd;
                if (!unit_last) begin
                    bit_count_ff <= bit_count_ff + 4'h1;
                    if (state_ff == ST_FCS) begin
                        shift_ff <= {shift_ff[14:0], 1'b0};
                    end else begin
                        shift_ff <= {1'b0, shift_ff[15:1]};
                    end
                end else begin
                    state_ff <= nxt_state;
                    bit_count_ff <= 4'h0;
                    case (nxt_state)
                        ST_DATA: begin
                            shift_ff <= {8'h00, hold_data_ff};
                            if (state_ff != ST_DATA) begin
                                crc_ff <= `CRC_INIT;
                            end
                        end
                        ST_FCS: begin
                            shift_ff <= crc_upd;
                        end
                        ST_ABORT, ST_UDR_ABORT: begin
                            shift_ff <= `ABORT_PATTERN;
                        end
                        ST_ALL_ONES: begin
                            shift_ff <= `ONES_PATTERN;
                        end
                        default: begin
                            shift_ff <= `FLAG_PATTERN;
                        end
                    endcase
                end
            end
        end
    end

    // Register reads answer one cycle after the strobe
    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else if (i_read) begin
            case (i_addr)
                `DL_TX_CONFIG_ADDR: begin
                    o_rdata <= {3'b000, end_of_packet_mark_ff, irq_gate_bit_ff,
                        abort_request_ff, crc_enable_ff, enable_ff};
                end
                `DL_TX_STATUS_ADDR: begin
                    o_rdata <= {6'h00, byte_request, underrun_flag_ff};
                end
                `DL_TX_DATA_ADDR: begin
                    o_rdata <= hold_data_ff;
                end
                `DL_TX_OPTIONS_ADDR: begin
                    o_rdata <= {7'h00, route_enable_ff};
                end
                default: begin
                    o_rdata <= 8'h00;
                end
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    assign o_dl_bit = line_bit_ff;
    assign o_datalink_irq_out = irq_gate_bit_ff && byte_request;
    assign o_cpu_irq_n = ~(o_datalink_irq_out && route_enable_ff);

endmodule

// ---- sim/hdlc_tx_checker_assertions.sv ----
/* Port checker for the HDLC transmitter.
   Assumes a bind to the design top; config writes are shadowed here. */
`timescale 1ns/1ns
module hdlc_tx_checker (
    input wire i_clock,
    input wire i_reset,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_write,
    input wire i_read,
    input wire [7:0] o_rdata,
    input wire i_bit_strobe,
    input wire o_dl_bit,
    input wire o_datalink_irq_out,
    input wire o_cpu_irq_n
);
    reg en_ff, gate_ff, route_ff, hold_ff;
    wire wr_cfg = i_write && i_addr == 8'h34;
    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            en_ff <= 1'b0;
            gate_ff <= 1'b0;
            route_ff <= 1'b0;
            hold_ff <= 1'b0;
        end else begin
            en_ff <= wr_cfg ? i_wdata[0] : en_ff;
            gate_ff <= wr_cfg ? i_wdata[3] : gate_ff;
            route_ff <= (i_write && i_addr == 8'h3F) ? i_wdata[0] : route_ff;
            // Any enabled strobe might load the held byte, so stop claiming it
            hold_ff <= (i_write && i_addr == 8'h36) | (hold_ff & !(i_bit_strobe & en_ff));
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);
    property p_reset_vals;
        $fell(i_reset) |-> o_dl_bit && !o_datalink_irq_out && o_cpu_irq_n && o_rdata == 8'h00;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad outputs after reset");
    property p_gate;
        !gate_ff |-> !o_datalink_irq_out;
    endproperty
    a_gate: assert property (p_gate) else $error("interrupt while gated off");
    property p_route;
        route_ff |-> o_cpu_irq_n == !o_datalink_irq_out;
    endproperty
    a_route: assert property (p_route) else $error("cpu interrupt not following");
    property p_noroute;
        !route_ff |-> o_cpu_irq_n;
    endproperty
    a_noroute: assert property (p_noroute) else $error("cpu interrupt not routed");
    property p_disabled;
        !en_ff && !$past(en_ff) && !$past(en_ff, 2) |-> o_dl_bit;
    endproperty
    a_disabled: assert property (p_disabled) else $error("line active while off");
    property p_line_hold;
        !$past(i_bit_strobe) && !$past(i_write) && !$past(i_write, 2) |-> $stable(o_dl_bit);
    endproperty
    a_line_hold: assert property (p_line_hold) else $error("line moved off slot");
    property p_req_low;
        hold_ff && i_read && i_addr == 8'h35 && !i_bit_strobe |=> !o_rdata[1];
    endproperty
    a_req_low: assert property (p_req_low) else $error("request set with byte held");
    property p_irq_req;
        $past(i_read && i_addr == 8'h35 && gate_ff) && o_rdata[1] |-> $past(o_datalink_irq_out);
    endproperty
    a_irq_req: assert property (p_irq_req) else $error("request without interrupt");
endmodule
bind hdlc_datalink_transmitter hdlc_tx_checker chk_inst (
    .i_clock(i_clock), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .i_bit_strobe(i_bit_strobe),
    .o_dl_bit(o_dl_bit), .o_datalink_irq_out(o_datalink_irq_out), .o_cpu_irq_n(o_cpu_irq_n)
);

// ---- sim/dl_framer_model.sv ----
/* Framer-side model: pulses the bit slot strobe and samples the line.
   Assumes the line bit settles the cycle after the strobe. */
`timescale 1ns/1ns
module dl_framer_model #(parameter [7:0] PERIOD = 8'h08) (
    input wire i_clock,
    input wire i_reset,
    input wire i_line,
    output reg o_strobe,
    output reg o_bit_valid,
    output reg o_bit
);
    reg [7:0] cnt_ff;
    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            cnt_ff <= 8'h00;
            o_strobe <= 1'b0;
            o_bit_valid <= 1'b0;
            o_bit <= 1'b1;
        end else begin
            cnt_ff <= (cnt_ff == PERIOD - 8'h01) ? 8'h00 : cnt_ff + 8'h01;
            o_strobe <= (cnt_ff == PERIOD - 8'h01);
            // Sample one cycle after the strobe is taken, once the line has moved
            o_bit_valid <= (cnt_ff == 8'h01);
            o_bit <= i_line;
        end
    end
endmodule

// ---- sim/hdlc_datalink_transmitter_tb_top.sv ----
/* Self-checking bench: register tasks and a frame decoder on the line.
   Assumes the framer model supplies the bit slots. */
`timescale 1ns/1ns
module hdlc_datalink_transmitter_tb_top;
    reg i_clock, i_reset, i_write, i_read, rd_d;
    reg [7:0] i_addr, i_wdata;
    wire [7:0] o_rdata;
    wire strobe, bit_valid, bit_val, o_dl_bit, o_datalink_irq_out, o_cpu_irq_n;
    integer num_errors = 0, total_checks = 0;
    reg [7:0] exp_rd[$];
    reg exp_bits[$], fr[$];
    reg [7:0] sh = 8'hFF;
    reg [15:0] ones = 16'h0000, last_run = 16'h0000, crc;
    hdlc_datalink_transmitter uut (.i_clock(i_clock), .i_reset(i_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
        .i_bit_strobe(strobe), .o_dl_bit(o_dl_bit), .o_datalink_irq_out(o_datalink_irq_out),
        .o_cpu_irq_n(o_cpu_irq_n));
    dl_framer_model #(.PERIOD(8'h08)) framer (.i_clock(i_clock), .i_reset(i_reset),
        .i_line(o_dl_bit), .o_strobe(strobe), .o_bit_valid(bit_valid), .o_bit(bit_val));
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    task chk(input [15:0] got, input [15:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge i_clock);
        i_write <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_write <= 1'b0;
    endtask
    task rd(input [7:0] a, input [7:0] e);
        @(posedge i_clock);
        i_read <= 1'b1;
        i_addr <= a;
        exp_rd.push_back(e);
        @(posedge i_clock);
        i_read <= 1'b0;
    endtask
    // Look at the request after the edge's updates have landed
    task wirq;
        @(negedge i_clock);
        for (int t = 0; t < 500 && o_datalink_irq_out !== 1'b1; t++) @(negedge i_clock);
    endtask
    task send_frame(input int n, input reg crc_on, input reg first);
        reg [7:0] cfg, b;
        cfg = {5'h01, 1'b0, crc_on, 1'b1};
        crc = 16'hFFFF;
        wr(8'h34, cfg);
        for (int i = 0; i < n; i++) begin
            b = (i == 0) ? 8'hFF : 8'($urandom);
            wirq;
            wr(8'h36, b);
            if (first && i == 0) rd(8'h35, 8'h00);
            for (int j = 0; j < 8; j++) begin
                exp_bits.push_back(b[j]);
                crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b[j]) ? 16'h1021 : 16'h0000);
            end
        end
        wr(8'h34, cfg | 8'h10);
        if (crc_on) for (int j = 15; j >= 0; j--) exp_bits.push_back(crc[j]);
        for (int t = 0; t < 3000 && exp_bits.size() > 0; t++) @(posedge i_clock);
        rd(8'h34, cfg);
    endtask
    always @(posedge i_clock) begin
        if (rd_d) chk({8'h00, o_rdata}, {8'h00, exp_rd.pop_front()});
        rd_d <= i_read;
    end
    always @(posedge i_clock) begin
        if (bit_valid) begin
            sh = {sh[6:0], bit_val};
            if (bit_val) ones = ones + 16'h0001;
            if (sh == 8'h7E) begin
                // Runs this short between flags are fill, never a frame
                if (fr.size() >= 15)
                    for (int k = 0; k < fr.size() - 7; k++) chk(16'(fr[k]), 16'(exp_bits.pop_front()));
                fr.delete();
            end else if (ones >= 16'h0007) fr.delete();
            else if (bit_val || ones != 16'h0005) fr.push_back(bit_val);
            if (!bit_val) begin
                last_run = ones;
                ones = 16'h0000;
            end
        end
    end
    initial begin
        i_reset = 1'b1;
        i_write = 1'b0;
        i_read = 1'b0;
        rd_d = 1'b0;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        void'($urandom(43));
        repeat (6) @(posedge i_clock);
        i_reset <= 1'b0;
        rd(8'h34, 8'h00);
        rd(8'h35, 8'h02);
        wr(8'h40, 8'hFF);
        rd(8'h40, 8'h00);
        wr(8'h3F, 8'h01);
        send_frame(4, 1'b1, 1'b1);
        wirq;
        wr(8'h36, 8'h5A);
        repeat (200) @(posedge i_clock);
        rd(8'h35, 8'h03);
        wr(8'h35, 8'h03);
        repeat (400) @(posedge i_clock);
        chk(16'(ones >= 16'h0010), 16'h0001);
        rd(8'h35, 8'h03);
        wr(8'h35, 8'h00);
        rd(8'h35, 8'h02);
        wr(8'h34, 8'h0D);
        repeat (200) @(posedge i_clock);
        chk(last_run, 16'h0007);
        send_frame(2, 1'b0, 1'b0);
        chk(16'(exp_bits.size()), 16'h0000);
        give_verdict;
    end
    initial begin
        #200000;
        num_errors = num_errors + 1;
        give_verdict;
    end
endmodule
